// >>> logic/pcb_decode_regs.vh
// Purpose: constants for the relocatable peripheral register block decode
// Assumes: 20-bit physical address, 16-bit internal data path
// Notes:   definitions only
`ifndef PCB_DECODE_REGS_VH
`define PCB_DECODE_REGS_VH

`define RELOC_OFFSET      8'hFE
`define RELOC_RESET       16'h20FF
`define RELOC_BASE_MSB    11
`define RELOC_MEM_BIT     12
`define RELOC_ESC_BIT     13
`define RELOC_CMPT_BIT    14
`define TIMER_LO          8'h50
`define TIMER_HI          8'h5F
`define TIMER_WAITS       2'h1
`define NO_WAITS          2'h0
`define UPPER_LO          8'hA0
`define UNMAPPED_RDATA    16'h0000

`endif

// >>> logic/pcb_offset_map.v
// Purpose: classify an offset inside the register block
// Assumes: offsets are byte offsets from the block base
// Notes:   purely combinational
`timescale 1ns/100ps
`include "pcb_decode_regs.vh"

module pcb_offset_map
(
    // offset in
    input  wire [7:0] offset_i,
    // class out
    output wire       is_reloc_o,
    output wire       is_timer_o,
    output wire       is_periph_o
);

    wire [7:0] reloc_offset;

    assign reloc_offset = `RELOC_OFFSET;
    // relocation word decodes on bits 7:1; odd byte lands in it too
    assign is_reloc_o  = (offset_i[7:1] == reloc_offset[7:1]);
    // timer control and counting registers
    assign is_timer_o  = (offset_i >= `TIMER_LO) && (offset_i <= `TIMER_HI);
    // locations owned by an outside peripheral register file
    assign is_periph_o = is_timer_o || (offset_i < `TIMER_LO) || (offset_i >= `UPPER_LO && offset_i < `RELOC_OFFSET);

endmodule

// >>> logic/peripheral_block_decode.v
// Purpose: decode, ready and data steering for the relocatable register block
// Assumes: one access request pulse per bus cycle from the bus unit
// Notes:   peripherals themselves sit outside; this block holds relocation only
//          byte accesses are treated as words; odd byte reads return the word
//          external ready is assumed already in step with mclk_i
//
// Behaviour
// - decode 256-byte block on any boundary
// - relocation word sits at block offset FE
// - relocation holds compat-mode and escape-trap bits
// - reset value places block at top I/O
// - writing 1100 moves block to memory 10000
// - unmapped writes complete but store nothing
// - block accesses still run external bus cycles
// - external read data ignored inside block
// - internal ready, external ready ignored inside block
// - zero wait states except timers
// - timer accesses take exactly one wait
// - any write updates all 16 bits
// - even byte reads valid, odd undefined
// - narrow bus: single cycle, low byte driven
`timescale 1ns/100ps
`include "pcb_decode_regs.vh"

module peripheral_block_decode
(
    // clock and reset
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    // bus unit request
    input  wire        req_i,
    input  wire        req_mem_i,
    input  wire        req_wr_i,
    input  wire [19:0] req_addr_i,
    input  wire [15:0] req_wdata_i,
    input  wire        narrow_bus_i,
    // external bus answer
    input  wire        ext_ready_i,
    input  wire [15:0] ext_rdata_i,
    // peripheral register file answer
    input  wire [15:0] periph_rdata_i,
    // bus unit answer
    output reg         done_o,
    output reg  [15:0] rdata_o,
    // external bus cycle
    output reg         ext_cycle_o,
    output reg  [19:0] ext_addr_o,
    output reg  [15:0] ext_wdata_o,
    output reg         ext_wr_o,
    output reg         ext_mem_o,
    // peripheral strobes
    output reg         periph_wr_o,
    output reg  [7:0]  periph_offset_o,
    output reg  [15:0] periph_wdata_o,
    // relocation controls
    output reg         esc_trap_o,
    output reg         int_compat_o
);

    ////////////////////////////////////////////////////////////////////////
    // state
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_EXT  = 3'b100;

    reg [2:0]  state_q;
    reg [15:0] reloc_q;
    reg [1:0]  wait_q;
    reg        inblk_q;
    reg        wr_q;
    reg        is_reloc_q;
    reg        is_periph_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_d;

    wire        hit;
    wire        is_reloc;
    wire        is_timer;
    wire        is_periph;
    wire [11:0] reloc_base;
    wire        reloc_mem;

    ////////////////////////////////////////////////////////////////////////
    // relocation word fields
    // the base field is address bits 19:8, so the block always starts on a
    // 256-byte boundary; the space bit picks memory when set, I/O when clear
    assign reloc_base = reloc_q[`RELOC_BASE_MSB:0];
    assign reloc_mem  = reloc_q[`RELOC_MEM_BIT];

    // block hit: space matches and address bits 19:8 equal base
    assign hit = (req_mem_i == reloc_mem) &&
                 (req_addr_i[19:8] == reloc_base);

    pcb_offset_map u_map
    (
        .offset_i    (req_addr_i[7:0]),
        .is_reloc_o  (is_reloc),
        .is_timer_o  (is_timer),
        .is_periph_o (is_periph)
    );

    ////////////////////////////////////////////////////////////////////////
    // internal read data
    // data from the external device is never chosen on a block access, and
    // an unassigned offset reads as zero so a value written there never
    // comes back
    always @*
    begin
        rdata_d = `UNMAPPED_RDATA;
        if (is_reloc_q)
            rdata_d = reloc_q;
        else if (is_periph_q)
            rdata_d = periph_rdata_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // relocation mode outputs
    // registered copies of the mode bits; they follow a write one clock after
    // it completes, which is early enough since the bus unit cannot start
    // another instruction any sooner
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            esc_trap_o   <= 1'b0;
            int_compat_o <= 1'b0;
        end
        else
        begin
            esc_trap_o   <= reloc_q[`RELOC_ESC_BIT];
            int_compat_o <= reloc_q[`RELOC_CMPT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_q         <= ST_IDLE;
            reloc_q         <= `RELOC_RESET;
            wait_q          <= `NO_WAITS;
            inblk_q         <= 1'b0;
            wr_q            <= 1'b0;
            is_reloc_q      <= 1'b0;
            is_periph_q     <= 1'b0;
            wdata_q         <= 16'h0000;
            done_o          <= 1'b0;
            rdata_o         <= 16'h0000;
            ext_cycle_o     <= 1'b0;
            ext_addr_o      <= 20'h0_0000;
            ext_wdata_o     <= 16'h0000;
            ext_wr_o        <= 1'b0;
            ext_mem_o       <= 1'b0;
            periph_wr_o     <= 1'b0;
            periph_offset_o <= 8'h00;
            periph_wdata_o  <= 16'h0000;
        end
        else
        begin
            done_o      <= 1'b0;
            periph_wr_o <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (req_i)
                    begin
                        // every access also runs on the pins, inside or not
                        ext_cycle_o     <= 1'b1;
                        ext_addr_o      <= req_addr_i;
                        ext_wr_o        <= req_wr_i;
                        ext_mem_o       <= req_mem_i;
                        // narrow bus carries the low byte only, one cycle
                        ext_wdata_o     <= narrow_bus_i ? {8'h00, req_wdata_i[7:0]} : req_wdata_i;
                        inblk_q         <= hit;
                        wr_q            <= req_wr_i;
                        is_reloc_q      <= is_reloc;
                        is_periph_q     <= is_periph;
                        wdata_q         <= req_wdata_i;
                        periph_offset_o <= req_addr_i[7:0];
                        wait_q          <= (hit && is_timer) ? `TIMER_WAITS : `NO_WAITS;
                        // full word written even for a byte opcode
                        // only mapped offsets get a strobe; an unassigned write is dropped
                        if (hit && req_wr_i && is_periph)
                        begin
                            periph_wr_o    <= 1'b1;
                            periph_wdata_o <= req_wdata_i;
                        end
                        state_q <= hit ? ST_WAIT : ST_EXT;
                    end
                end
                ST_WAIT:
                begin
                    // internal ready; external ready never looked at here, and
                    // req_i is ignored while busy, so an early request is lost
                    if (wait_q == `NO_WAITS)
                    begin
                        done_o      <= 1'b1;
                        ext_cycle_o <= 1'b0;
                        state_q     <= ST_IDLE;
                        if (wr_q && is_reloc_q)
                            reloc_q <= wdata_q;
                        // reads return internal data only; odd byte is left to the bus unit
                        rdata_o <= rdata_d;
                    end
                    else
                        // the single timer wait lets the counters share the registers
                        wait_q <= wait_q - 2'h1;
                end
                ST_EXT:
                begin
                    // outside the block the external device sets the length
                    if (ext_ready_i)
                    begin
                        done_o      <= 1'b1;
                        rdata_o     <= ext_rdata_i;
                        ext_cycle_o <= 1'b0;
                        state_q     <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

endmodule

// >>> tb/pbd_assertions.sv
// Purpose: timing and decode checks at the register block ports
// Assumes: bus unit requests only while idle, words only
// Notes:   relocation is mirrored from requests, not from internals
`timescale 1ns/100ps
module pbd_assertions
(
    input wire        mclk_i, sys_rst_i, req_i, req_mem_i, req_wr_i,
    input wire        ext_ready_i, done_o, ext_cycle_o, periph_wr_o,
    input wire [19:0] req_addr_i, ext_addr_o,
    input wire [15:0] req_wdata_i, periph_wdata_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (sys_rst_i);
reg  [15:0] rl_q;
reg         hit_q;
wire        hit = req_mem_i == rl_q[12] && req_addr_i[19:8] == rl_q[11:0];
wire        tmr = req_addr_i[7:4] == 4'h5;
// shadow of the relocation word; a write there moves the decode for the next request
always @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
        rl_q  <= 16'h20FF;
        hit_q <= 1'b0;
    end
    else
    begin
        if (req_i && req_wr_i && hit && req_addr_i[7:1] == 7'h7F)
            rl_q <= req_wdata_i;
        if (req_i)
            hit_q <= hit;
    end
sequence s_blk; !done_o ##1 done_o; endsequence
sequence s_tmr; !done_o [*2] ##1 done_o; endsequence
a_blk_ready: assert property (req_i && hit && !tmr |=> s_blk) else $error("block access not done in 2");
a_tmr_wait: assert property (req_i && hit && tmr |=> s_tmr) else $error("timer access not done in 3");
a_ext_cycle: assert property (req_i |=> ext_cycle_o && ext_addr_o == $past(req_addr_i)) else $error("no ext cycle");
a_ext_ready: assert property (done_o && !hit_q |-> $past(ext_ready_i) || $past(ext_ready_i, 2))
    else $error("outside access done without ready");
a_wr_strobe: assert property (req_i && req_wr_i && hit && (req_addr_i[7:0] < 8'h60 ||
    req_addr_i[7:0] >= 8'hA0 && req_addr_i[7:0] < 8'hFE) |=> periph_wr_o && periph_wdata_o == $past(req_wdata_i))
    else $error("write not passed whole");
a_gap_quiet: assert property (req_i && req_wr_i && hit && req_addr_i[7:4] >= 4'h6 && req_addr_i[7:4] <= 4'h9
    |=> !periph_wr_o) else $error("write stored at unassigned offset");
a_no_stray: assert property (req_i && !hit |=> !periph_wr_o) else $error("write outside block");
a_wr_cause: assert property (periph_wr_o |-> $past(req_i && req_wr_i)) else $error("write strobe uncaused");
a_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than a cycle");
endmodule
bind peripheral_block_decode pbd_assertions u_chk (.mclk_i, .sys_rst_i, .req_i, .req_mem_i, .req_wr_i,
    .ext_ready_i, .done_o, .ext_cycle_o, .periph_wr_o, .req_addr_i, .ext_addr_o, .req_wdata_i, .periph_wdata_o);

// >>> tb/ext_bus_model.sv
// Purpose: external device answering the mirrored bus cycles
// Assumes: ready comes on the third cycle of a bus cycle
// Notes:   idle data changes every cycle so a stale value never matches
`timescale 1ns/100ps
module ext_bus_model
(
    input  wire        mclk_i, sys_rst_i, ext_cycle_o,
    output wire        ext_ready_i,
    output wire [15:0] ext_rdata_i
);
reg [1:0]  cnt_q;
reg [15:0] run_q;
always @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
        cnt_q <= 2'h0;
        run_q <= 16'h0000;
    end
    else
    begin
        cnt_q <= ext_cycle_o ? cnt_q + 2'h1 : 2'h0;
        run_q <= run_q + 16'h0001;
    end
assign ext_ready_i = cnt_q == 2'h2;
assign ext_rdata_i = ext_ready_i ? 16'hC3A5 : ~run_q;
endmodule

// >>> tb/peripheral_block_decode_tb.sv
// Purpose: directed checks of decode, waits and relocation
// Assumes: one word request at a time
// Notes:   peripheral data is coded from the offset
`timescale 1ns/100ps
module peripheral_block_decode_tb;
reg mclk_i = 1'b0, sys_rst_i = 1'b1, req_i = 1'b0, req_mem_i = 1'b0, req_wr_i = 1'b0, narrow_bus_i = 1'b0;
reg  [19:0] req_addr_i = 20'h0_0000;
reg  [15:0] req_wdata_i = 16'h0000, rd;
wire ext_ready_i, done_o, ext_cycle_o, ext_wr_o, ext_mem_o, periph_wr_o, esc_trap_o, int_compat_o;
wire [15:0] ext_rdata_i, rdata_o, ext_wdata_o, periph_wdata_o;
wire [19:0] ext_addr_o;
wire [7:0]  periph_offset_o;
wire [15:0] periph_rdata_i = {periph_offset_o, ~periph_offset_o};
integer n_mismatch = 0, checked = 0, cyc = 0;
peripheral_block_decode u_dut (.mclk_i, .sys_rst_i, .req_i, .req_mem_i, .req_wr_i, .req_addr_i, .req_wdata_i,
    .narrow_bus_i, .ext_ready_i, .ext_rdata_i, .periph_rdata_i, .done_o, .rdata_o, .ext_cycle_o, .ext_addr_o,
    .ext_wdata_o, .ext_wr_o, .ext_mem_o, .periph_wr_o, .periph_offset_o, .periph_wdata_o, .esc_trap_o, .int_compat_o);
ext_bus_model u_ext (.mclk_i, .sys_rst_i, .ext_cycle_o, .ext_ready_i, .ext_rdata_i);
initial forever #12.5 mclk_i = ~mclk_i;
task chk(input [19:0] got, input [19:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    end
endtask
// one word access; lat below zero skips the wait count
task acc(input m, input w, input [19:0] a, input [15:0] d, input integer lat);
    integer n;
    begin
        @(posedge mclk_i);
        {req_i, req_mem_i, req_wr_i, req_addr_i, req_wdata_i} <= {1'b1, m, w, a, d};
        @(posedge mclk_i);
        req_i <= 1'b0;
        #1;
        chk(ext_addr_o, a);
        chk(ext_wr_o, w);
        chk(ext_mem_o, m);
        if (w)
            chk(ext_wdata_o[7:0], d[7:0]);
        n = 1;
        while (done_o !== 1'b1 && n < 8)
        begin
            @(posedge mclk_i);
            #1;
            n = n + 1;
        end
        if (lat >= 0)
            chk(n, lat);
        rd = rdata_o;
    end
endtask
task t_reset;
    begin
        chk(esc_trap_o, 0);
        acc(0, 0, 20'h0_FFFE, 0, 2);
        chk(rd, 16'h20FF);
        chk({esc_trap_o, int_compat_o}, 2'h2);
        $display("test reset done");
    end
endtask
task t_wait;
    begin
        acc(0, 0, 20'h0_FF50, 0, 3);
        chk(rd, 16'h50AF);
        acc(0, 1, 20'h0_FF5E, 16'h1234, 3);
        chk(periph_wdata_o, 16'h1234);
        chk(periph_offset_o, 8'h5E);
        acc(0, 0, 20'h0_FF4E, 0, 2);
        chk(rd, 16'h4EB1);
        $display("test wait done");
    end
endtask
task t_move;
    begin
        acc(0, 1, 20'h0_FFFE, 16'h1100, 2);
        acc(0, 0, 20'h0_FFFE, 0, -1);
        chk(rd, 16'hC3A5);
        acc(1, 0, 20'h1_00FE, 0, 2);
        chk(rd, 16'h1100);
        chk({esc_trap_o, int_compat_o}, 2'h0);
        acc(1, 1, 20'h1_00FE, 16'h6100, 2);
        acc(0, 0, 20'h1_00FE, 0, 2);
        chk(rd, 16'h6100);
        chk({esc_trap_o, int_compat_o}, 2'h3);
        $display("test move done");
    end
endtask
task t_narrow;
    begin
        @(posedge mclk_i);
        narrow_bus_i <= 1'b1;
        acc(0, 1, 20'h1_0000, 16'hBEEF, 2);
        chk(ext_wdata_o, 16'h00EF);
        $display("test narrow done");
    end
endtask
task t_gap;
    begin
        acc(0, 1, 20'h0_FF60, 16'h5A5A, 2);
        acc(0, 0, 20'h0_FF60, 0, 2);
        chk(rd, 16'h0000);
        $display("test gap done");
    end
endtask
task t_rerst;
    begin
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        acc(0, 0, 20'h0_FFFE, 0, 2);
        chk(rd, 16'h20FF);
        chk({esc_trap_o, int_compat_o}, 2'h2);
        $display("test rerst done");
    end
endtask
task finish_test;
    begin
        $display("%0d compared, %0d mismatched", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask
// hang guard, far above the fifty or so cycles the tests need
always @(posedge mclk_i)
begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
end
initial
begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_wait;
    t_gap;
    t_move;
    t_narrow;
    t_rerst;
    finish_test;
end
endmodule
